// file: design/fldr_pkg.sv
// How it works
// - Writing 0x55 to the identity register restores all defaults.
// - Control register at 0x01 is read/write, resets to 0x00.
// - Control bit 7 picks edge or level trigger; bit 6 enables trigger.
// - Mode bits decode standby, infrared drive, torch and flash.
// - Control bits 1 and 0 enable channels b and a; bits 3:2 reserved.
// - Supply monitor register at 0x02 resets to 0xe1.
// - Supply bit 4 enables undervoltage guard; bits 7:6 reserved.
// - Supply bit 5 enables channel short detection, default on.
// - Supply bits 3:1 pick droop threshold; bit 0 enables droop monitor.
// - Flash current registers 0x03 and 0x05 hold codes, default 0x7f.
// - Torch current registers 0x04 and 0x06 hold codes, default 0x7f.
// - Timing bits 7:4 pick the torch ramp time.
// - Timing bits 3:0 pick flash timeout; register resets to 0x1a.
// - Flag register 0x0f is read-only; bit 7 timeout, bit 6 droop.
// - Flag bits 3,2 channel shorts; bit 1 thermal; bit 0 undervoltage.
// - Reading the flag register clears the latched flags.
// - Short, or timeout in flash/infrared mode, forces standby.
// - Register address advances by one after each acknowledged data byte.
package fldr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] A_CHIP_ID = 8'h00;
    localparam logic [7:0] A_CTRL    = 8'h01;
    localparam logic [7:0] A_SUPPLY  = 8'h02;
    localparam logic [7:0] A_A_FLASH = 8'h03;
    localparam logic [7:0] A_A_TORCH = 8'h04;
    localparam logic [7:0] A_B_FLASH = 8'h05;
    localparam logic [7:0] A_B_TORCH = 8'h06;
    localparam logic [7:0] A_TIMING  = 8'h0b;
    localparam logic [7:0] A_FLAGS   = 8'h0f;
    localparam logic [7:0] A_DEV_ID  = 8'h10;
    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] R_CTRL    = 8'h00;
    localparam logic [7:0] R_SUPPLY  = 8'he1;
    localparam logic [7:0] R_CURRENT = 8'h7f;
    localparam logic [7:0] R_TIMING  = 8'h1a;
    localparam logic [7:0] R_FLAGS   = 8'h00;
    localparam logic [7:0] SOFT_KEY  = 8'h55;
    localparam logic [7:0] M_CTRL    = 8'hf3;
    localparam logic [7:0] M_SUPPLY  = 8'h3f;
    // Arbitrary identity values and bus address
    localparam logic [7:0] CHIP_ID   = 8'h3c;
    localparam logic [7:0] DEV_ID    = 8'h5a;
    localparam logic [6:0] BUS_ADDR  = 7'h2a;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_IR      = 2'b01,
        MODE_TORCH   = 2'b10,
        MODE_FLASH   = 2'b11
    } fldr_mode_t;
    typedef struct packed {
        logic       trig_edge;
        logic       trig_en;
        fldr_mode_t mode;
        logic [1:0] rsvd;
        logic       chb_en;
        logic       cha_en;
    } fldr_ctrl_t;
    typedef struct packed {
        logic [1:0] rsvd;
        logic       short_det_en;
        logic       supply_undervoltage_guard_en;
        logic [2:0] droop_thr;
        logic       droop_en;
    } fldr_supply_t;
    typedef struct packed {
        logic [3:0] ramp;
        logic [3:0] timeout;
    } fldr_timing_t;
    typedef struct packed {
        logic       timeout;
        logic       droop;
        logic [1:0] rsvd;
        logic       short_b;
        logic       short_a;
        logic       thermal;
        logic       supply_undervoltage_guard;
    } fldr_flags_t;
    typedef struct packed {
        logic flash_timeout;
        logic droop_trip;
        logic short_b;
        logic short_a;
        logic thermal;
        logic supply_undervoltage_guard;
    } fldr_fault_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_HOST_ACK, ST_WAIT_STOP
    } fldr_state_t;
endpackage

// file: design/fldr_regs.sv
`timescale 1ns/1ps
module fldr_regs (
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    input  wire logic                   scl_i,
    input  wire logic                   sda_i,
    output logic                        sda_o,
    output logic                        sda_oe_o,
    input  wire fldr_pkg::fldr_fault_t  fault_i,
    output fldr_pkg::fldr_ctrl_t        ctrl_o,
    output fldr_pkg::fldr_supply_t      supply_o,
    output logic [7:0]                  cha_flash_o,
    output logic [7:0]                  cha_torch_o,
    output logic [7:0]                  chb_flash_o,
    output logic [7:0]                  chb_torch_o,
    output fldr_pkg::fldr_timing_t      timing_o
);
    fldr_pkg::fldr_state_t  state_q;
    fldr_pkg::fldr_ctrl_t   ctrl_q;
    fldr_pkg::fldr_supply_t supply_q;
    fldr_pkg::fldr_timing_t timing_q;
    fldr_pkg::fldr_flags_t  flags_q;
    fldr_pkg::fldr_flags_t  flags_d;
    fldr_pkg::fldr_fault_t  flt_meta_q;
    fldr_pkg::fldr_fault_t  flt_q;
    logic [7:0] a_flash_q;
    logic [7:0] a_torch_q;
    logic [7:0] b_flash_q;
    logic [7:0] b_torch_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic [7:0] rd_byte;
    logic [3:0] bit_cnt_q;
    logic       rw_q;
    logic       host_ack_q;
    logic       sda_oe_q;
    logic       scl_meta_q;
    logic       scl_q;
    logic       scl_prev_q;
    logic       sda_meta_q;
    logic       sda_q;
    logic       sda_prev_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       byte_full;
    logic       wr_stb;
    logic       soft_rst;
    logic       rd_load;
    logic       rd_clr;
    logic       mode_kill;

    // ------------------------------------------------------------
    // Pin and fault synchronisers
    // ------------------------------------------------------------
    // Two stages each; the pins then get a history stage for edge finding
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_meta_q <= 1'b1;
            scl_q      <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_q      <= 1'b1;
            sda_prev_q <= 1'b1;
            flt_meta_q <= '0;
            flt_q      <= '0;
        end else if (ce_i) begin
            scl_meta_q <= scl_i;
            scl_q      <= scl_meta_q;
            scl_prev_q <= scl_q;
            sda_meta_q <= sda_i;
            sda_q      <= sda_meta_q;
            sda_prev_q <= sda_q;
            flt_meta_q <= fault_i;
            flt_q      <= flt_meta_q;
        end
    end

    // Bus events seen on the synchronised lines
    assign scl_rise  = scl_q & ~scl_prev_q;
    assign scl_fall  = ~scl_q & scl_prev_q;
    assign start_det = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
    assign stop_det  = scl_q & scl_prev_q & ~sda_prev_q & sda_q;
    assign byte_full = (bit_cnt_q == fldr_pkg::BYTE_BITS);

    // ------------------------------------------------------------
    // Byte protocol engine
    // ------------------------------------------------------------
    // Register write and read fetch strobes
    assign wr_stb  = ce_i & scl_fall & byte_full
                     & (state_q == fldr_pkg::ST_WDATA);
    assign rd_load = ce_i & scl_fall
                     & (((state_q == fldr_pkg::ST_ADDR_ACK) & rw_q)
                      | ((state_q == fldr_pkg::ST_HOST_ACK) & host_ack_q));
    assign rd_clr  = rd_load & (ptr_q == fldr_pkg::A_FLAGS);
    assign soft_rst = wr_stb & (ptr_q == fldr_pkg::A_CHIP_ID)
                      & (shift_q == fldr_pkg::SOFT_KEY);

    // Sequencing of address, pointer and data bytes
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q    <= fldr_pkg::ST_IDLE;
            bit_cnt_q  <= '0;
            shift_q    <= '0;
            rw_q       <= 1'b0;
            host_ack_q <= 1'b0;
            sda_oe_q   <= 1'b0;
        end else if (ce_i) begin
            if (stop_det) begin
                state_q  <= fldr_pkg::ST_IDLE;
                sda_oe_q <= 1'b0;
            end else if (start_det) begin
                state_q   <= fldr_pkg::ST_ADDR;
                bit_cnt_q <= '0;
                sda_oe_q  <= 1'b0;
            end else if (rd_load) begin
                shift_q   <= rd_byte;
                sda_oe_q  <= ~rd_byte[7];
                bit_cnt_q <= 4'h1;
                state_q   <= fldr_pkg::ST_RDATA;
            end else begin
                unique case (state_q)
                    fldr_pkg::ST_ADDR, fldr_pkg::ST_REG,
                    fldr_pkg::ST_WDATA: begin
                        if (scl_rise) begin
                            shift_q   <= {shift_q[6:0], sda_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && byte_full) begin
                            bit_cnt_q <= '0;
                            sda_oe_q  <= 1'b1;
                            if (state_q == fldr_pkg::ST_REG) begin
                                state_q <= fldr_pkg::ST_REG_ACK;
                            end else if (state_q == fldr_pkg::ST_WDATA) begin
                                state_q <= fldr_pkg::ST_WDATA_ACK;
                            end else if (shift_q[7:1]
                                         == fldr_pkg::BUS_ADDR) begin
                                rw_q    <= shift_q[0];
                                state_q <= fldr_pkg::ST_ADDR_ACK;
                            end else begin
                                sda_oe_q <= 1'b0;
                                state_q  <= fldr_pkg::ST_WAIT_STOP;
                            end
                        end
                    end
                    fldr_pkg::ST_ADDR_ACK, fldr_pkg::ST_REG_ACK,
                    fldr_pkg::ST_WDATA_ACK: begin
                        if (scl_fall) begin
                            sda_oe_q <= 1'b0;
                            if (state_q == fldr_pkg::ST_ADDR_ACK) begin
                                state_q <= fldr_pkg::ST_REG;
                            end else begin
                                state_q <= fldr_pkg::ST_WDATA;
                            end
                        end
                    end
                    fldr_pkg::ST_RDATA: begin
                        if (scl_fall && byte_full) begin
                            sda_oe_q <= 1'b0;
                            state_q  <= fldr_pkg::ST_HOST_ACK;
                        end else if (scl_fall) begin
                            sda_oe_q  <= ~shift_q[6];
                            shift_q   <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                    fldr_pkg::ST_HOST_ACK: begin
                        if (scl_rise) begin
                            host_ack_q <= ~sda_q;
                        end else if (scl_fall) begin
                            state_q <= fldr_pkg::ST_WAIT_STOP;
                        end
                    end
                    fldr_pkg::ST_IDLE, fldr_pkg::ST_WAIT_STOP: begin
                        state_q <= state_q;
                    end
                endcase
            end
        end
    end

    // Register pointer: loaded by the pointer byte, then advancing
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_q <= '0;
        end else if (ce_i) begin
            if (scl_fall && byte_full && state_q == fldr_pkg::ST_REG) begin
                ptr_q <= shift_q;
            end else if (wr_stb) begin
                ptr_q <= ptr_q + 8'h01;
            end else if (scl_rise && !sda_q
                         && state_q == fldr_pkg::ST_HOST_ACK) begin
                ptr_q <= ptr_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Faults that drop the mode back to standby
    assign mode_kill = (supply_q.short_det_en
                        & (flt_q.short_a | flt_q.short_b))
                       | (flt_q.flash_timeout
                          & ((ctrl_q.mode == fldr_pkg::MODE_FLASH)
                           | (ctrl_q.mode == fldr_pkg::MODE_IR)))
                       | flt_q.thermal
                       | (supply_q.supply_undervoltage_guard_en & flt_q.supply_undervoltage_guard);

    // Writable configuration registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q    <= fldr_pkg::R_CTRL;
            supply_q  <= fldr_pkg::R_SUPPLY;
            a_flash_q <= fldr_pkg::R_CURRENT;
            a_torch_q <= fldr_pkg::R_CURRENT;
            b_flash_q <= fldr_pkg::R_CURRENT;
            b_torch_q <= fldr_pkg::R_CURRENT;
            timing_q  <= fldr_pkg::R_TIMING;
        end else if (ce_i) begin
            if (soft_rst) begin
                ctrl_q    <= fldr_pkg::R_CTRL;
                supply_q  <= fldr_pkg::R_SUPPLY;
                a_flash_q <= fldr_pkg::R_CURRENT;
                a_torch_q <= fldr_pkg::R_CURRENT;
                b_flash_q <= fldr_pkg::R_CURRENT;
                b_torch_q <= fldr_pkg::R_CURRENT;
                timing_q  <= fldr_pkg::R_TIMING;
            end else if (wr_stb) begin
                unique case (ptr_q)
                    fldr_pkg::A_CTRL:
                        ctrl_q <= shift_q & fldr_pkg::M_CTRL;
                    fldr_pkg::A_SUPPLY:
                        supply_q <= (shift_q & fldr_pkg::M_SUPPLY)
                            | (supply_q & ~fldr_pkg::M_SUPPLY);
                    fldr_pkg::A_A_FLASH: a_flash_q <= shift_q;
                    fldr_pkg::A_A_TORCH: a_torch_q <= shift_q;
                    fldr_pkg::A_B_FLASH: b_flash_q <= shift_q;
                    fldr_pkg::A_B_TORCH: b_torch_q <= shift_q;
                    fldr_pkg::A_TIMING:  timing_q  <= shift_q;
                    default: timing_q <= timing_q;
                endcase
            end
            if (mode_kill) begin
                ctrl_q.mode <= fldr_pkg::MODE_STANDBY;
            end
        end
    end

    // New fault flags, droop, short and undervoltage gated by their enables; set wins over clear
    always_comb begin
        flags_d = (rd_clr || soft_rst) ? fldr_pkg::R_FLAGS : flags_q;
        flags_d.timeout = flags_d.timeout | flt_q.flash_timeout;
        flags_d.droop   = flags_d.droop
                          | (flt_q.droop_trip & supply_q.droop_en);
        flags_d.short_b = flags_d.short_b
                          | (flt_q.short_b & supply_q.short_det_en);
        flags_d.short_a = flags_d.short_a
                          | (flt_q.short_a & supply_q.short_det_en);
        flags_d.thermal = flags_d.thermal | flt_q.thermal;
        flags_d.supply_undervoltage_guard    = flags_d.supply_undervoltage_guard | (flt_q.supply_undervoltage_guard & supply_q.supply_undervoltage_guard_en);
        flags_d.rsvd    = 2'b00;
    end

    // Latched fault flags
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_q <= fldr_pkg::R_FLAGS;
        end else if (ce_i) begin
            flags_q <= flags_d;
        end
    end

    // Read data selection
    always_comb begin
        unique case (ptr_q)
            fldr_pkg::A_CHIP_ID: rd_byte = fldr_pkg::CHIP_ID;
            fldr_pkg::A_CTRL:    rd_byte = ctrl_q;
            fldr_pkg::A_SUPPLY:  rd_byte = supply_q;
            fldr_pkg::A_A_FLASH: rd_byte = a_flash_q;
            fldr_pkg::A_A_TORCH: rd_byte = a_torch_q;
            fldr_pkg::A_B_FLASH: rd_byte = b_flash_q;
            fldr_pkg::A_B_TORCH: rd_byte = b_torch_q;
            fldr_pkg::A_TIMING:  rd_byte = timing_q;
            fldr_pkg::A_FLAGS:   rd_byte = flags_q;
            fldr_pkg::A_DEV_ID:  rd_byte = fldr_pkg::DEV_ID;
            default:             rd_byte = 8'h00;
        endcase
    end

    // Open-drain data line only ever pulls low
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_o <= 1'b0;
        end else if (ce_i) begin
            sda_o <= 1'b0;
        end
    end

    assign sda_oe_o    = sda_oe_q;
    assign ctrl_o      = ctrl_q;
    assign supply_o    = supply_q;
    assign cha_flash_o = a_flash_q;
    assign cha_torch_o = a_torch_q;
    assign chb_flash_o = b_flash_q;
    assign chb_torch_o = b_torch_q;
    assign timing_o    = timing_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_soft_reset: assert property (
        soft_rst |=> ctrl_q == fldr_pkg::R_CTRL
                     && timing_q == fldr_pkg::R_TIMING
                     && a_flash_q == fldr_pkg::R_CURRENT)
        else $error("soft reset did not restore defaults");
    a_ctrl_rsvd_zero: assert property (ctrl_q.rsvd == 2'b00)
        else $error("control reserved bits not zero");
    a_supply_rsvd_fixed: assert property (
        $stable(supply_q.rsvd))
        else $error("supply reserved bits changed");
    a_flag_read_clear: assert property (
        rd_clr && flt_q == '0 |=> flags_q == fldr_pkg::R_FLAGS)
        else $error("flag read did not clear");
    a_flag_set_wins: assert property (
        ce_i && flt_q.flash_timeout |=> flags_q.timeout)
        else $error("timeout flag lost");
    a_short_standby: assert property (
        ce_i && supply_q.short_det_en && flt_q.short_a
        |=> ctrl_q.mode == fldr_pkg::MODE_STANDBY)
        else $error("short did not force standby");
    a_ptr_advance: assert property (
        wr_stb && !soft_rst |=> ptr_q == $past(ptr_q) + 8'h01)
        else $error("pointer did not advance");
    a_unmapped_zero: assert property (
        rd_load && ptr_q == 8'h07 |=> shift_q == 8'h00)
        else $error("unmapped read not zero");
    a_ack_release: assert property (
        ce_i && scl_fall && state_q == fldr_pkg::ST_WDATA_ACK
        && !start_det && !stop_det |=> !sda_oe_q)
        else $error("ack not released");

    c_soft_reset: cover property (soft_rst);
    c_flag_read: cover property (rd_clr && flags_q != '0);
    c_burst_write: cover property (wr_stb ##[1:1000] wr_stb);
    c_timeout_kill: cover property (
        flt_q.flash_timeout && ctrl_q.mode == fldr_pkg::MODE_FLASH);
endmodule

// file: verification/fldr_host_model.sv
`timescale 1ns/1ps
module fldr_host_model (
    input  wire logic sys_clk_i,
    input  wire logic sda_line_i,
    output logic      scl_o,
    output logic      sda_o
);
    // ----------------------------------------------------------
    // Bus controller, one bit takes eight system clocks (80 ns)
    // ----------------------------------------------------------
    // Idle bus: both lines released high
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Wait whole system clocks
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // One bit: data moves mid-low, wire sampled late in high phase
    task automatic bit_slot(input logic tx, output logic rx);
        tick(2);
        sda_o <= tx;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        rx = sda_line_i;
        scl_o <= 1'b0;
    endtask
    // Start or repeated start: data falls while clock is high
    task automatic start();
        sda_o <= 1'b1;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b0;
    endtask
    // Stop: data rises while clock is high, then the bus idles
    task automatic stop();
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b1;
        tick(4);
    endtask
    // Byte out MSB first, then the target's acknowledge slot
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic rx;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], rx);
        end
        bit_slot(1'b1, rx);
        ack = ~rx;
    endtask
    // Byte in MSB first; our acknowledge asks for the next byte
    task automatic rd_byte(output logic [7:0] b, input logic ack);
        logic rx;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, b[i]);
        end
        bit_slot(~ack, rx);
    endtask
endmodule

// file: verification/fldr_regs_test.sv
`timescale 1ns/1ps
module fldr_regs_test;
    // ----------------------------------------------------------
    // Signals, design and bus controller
    // ----------------------------------------------------------
    logic                   sys_clk_i  = 1'b0;
    logic                   rst_i      = 1'b1;
    logic                   ce_i       = 1'b1;
    logic                   sda_o;
    logic                   sda_oe_o;
    logic                   scl_w;
    logic                   host_sda;
    fldr_pkg::fldr_fault_t  fault_i    = '0;
    fldr_pkg::fldr_ctrl_t   ctrl_o;
    fldr_pkg::fldr_supply_t supply_o;
    fldr_pkg::fldr_timing_t timing_o;
    logic [7:0]             cha_flash_o;
    logic [7:0]             cha_torch_o;
    logic [7:0]             chb_flash_o;
    logic [7:0]             chb_torch_o;
    logic [7:0]             rd [17];
    int                     fails      = 0;
    int                     n_compared = 0;
    // Pulled-up data wire, low when either party pulls it
    wire                    sda_w = host_sda & (sda_oe_o ? sda_o : 1'b1);
    fldr_regs dut (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .scl_i       (scl_w),
        .sda_i       (sda_w),
        .sda_o       (sda_o),
        .sda_oe_o    (sda_oe_o),
        .fault_i     (fault_i),
        .ctrl_o      (ctrl_o),
        .supply_o    (supply_o),
        .cha_flash_o (cha_flash_o),
        .cha_torch_o (cha_torch_o),
        .chb_flash_o (chb_flash_o),
        .chb_torch_o (chb_torch_o),
        .timing_o    (timing_o)
    );
    fldr_host_model host (
        .sys_clk_i  (sys_clk_i),
        .sda_line_i (sda_w),
        .scl_o      (scl_w),
        .sda_o      (host_sda)
    );
    // System clock, 100 MHz
    always #5 sys_clk_i = ~sys_clk_i;
    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Seven output registers, control first, timing last
    task automatic chk_ports(input logic [55:0] e);
        logic [55:0] s;
        s = {ctrl_o, supply_o, cha_flash_o, cha_torch_o, chb_flash_o,
             chb_torch_o, timing_o};
        for (int i = 0; i < 7; i++) begin
            check(s[i*8 +: 8], e[i*8 +: 8]);
        end
    endtask
    task automatic open_ptr(input logic [7:0] ptr, input logic rnw);
        logic ack;
        host.start();
        host.wr_byte({fldr_pkg::BUS_ADDR, 1'b0}, ack);
        check({7'h0, ack}, 8'h01);
        host.wr_byte(ptr, ack);
        check({7'h0, ack}, 8'h01);
        if (rnw) begin
            host.start();
            host.wr_byte({fldr_pkg::BUS_ADDR, 1'b1}, ack);
            check({7'h0, ack}, 8'h01);
        end
    endtask
    task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d[$]);
        logic ack;
        open_ptr(ptr, 1'b0);
        foreach (d[i]) begin
            host.wr_byte(d[i], ack);
            check({7'h0, ack}, 8'h01);
        end
        host.stop();
    endtask
    // Burst read, last byte refused so the target stops sending
    task automatic reg_rd(input logic [7:0] ptr, input int n);
        open_ptr(ptr, 1'b1);
        for (int i = 0; i < n; i++) begin
            host.rd_byte(rd[i], i < n - 1);
        end
        host.stop();
    endtask
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_defaults();
        logic [7:0] e [17];
        e = '{fldr_pkg::CHIP_ID, 8'h00, 8'he1, 8'h7f, 8'h7f, 8'h7f, 8'h7f,
              8'h00, 8'h00, 8'h00, 8'h00, 8'h1a, 8'h00, 8'h00, 8'h00,
              8'h00, fldr_pkg::DEV_ID};
        chk_ports(56'h00_e1_7f_7f_7f_7f_1a);
        reg_rd(8'h00, 17);
        foreach (e[i]) check(rd[i], e[i]);
        $display("test defaults done");
    endtask
    // Bursts run across unmapped and read-only places
    // Trigger bits are only stored; pulse width is the host's duty
    task automatic t_write();
        logic [7:0] e [16];
        logic [7:0] v;
        e = '{8'hf3, 8'hca, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00,
              8'h00, 8'h00, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h00,
              fldr_pkg::DEV_ID};
        reg_wr(8'h01, '{8'hff, 8'h0a, 8'h11, 8'h22, 8'h33, 8'h44, 8'h99});
        reg_wr(8'h0b, '{8'ha5, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
        chk_ports(56'hf3_ca_11_22_33_44_a5);
        reg_rd(8'h01, 16);
        foreach (e[i]) check(rd[i], e[i]);
        for (int m = 0; m < 4; m++) begin
            v = {2'b00, 2'(m), 4'h0};
            reg_wr(8'h01, '{v});
            check(ctrl_o, v);
        end
        $display("test write done");
    endtask
    task automatic t_soft();
        reg_wr(8'h00, '{8'h54});
        check(ctrl_o, 8'h30);
        reg_wr(8'h00, '{8'h55});
        chk_ports(56'h00_e1_7f_7f_7f_7f_1a);
        $display("test soft reset done");
    endtask
    // Rows: supply, control, fault, expected control, expected flags
    task automatic t_faults();
        logic [39:0] row [11];
        row = '{40'h21_23_01_23_00, 40'h21_23_02_03_02, 40'h21_23_04_03_04,
                40'h21_23_08_03_08, 40'h21_23_10_23_40, 40'h21_23_20_23_80,
                40'h21_13_20_03_80, 40'h31_23_01_03_01, 40'h01_23_04_23_00,
                40'h21_33_20_03_80, 40'h20_23_10_23_00};
        foreach (row[i]) begin
            reg_wr(8'h01, '{row[i][31:24], row[i][39:32]});
            fault_i <= row[i][21:16];
            host.tick(10);
            fault_i <= '0;
            host.tick(4);
            check(ctrl_o, row[i][15:8]);
            reg_rd(8'h0f, 1);
            check(rd[0], row[i][7:0]);
            reg_rd(8'h0f, 1);
            check(rd[0], 8'h00);
        end
        $display("test faults done");
    endtask
    // ----------------------------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------------------------
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        host.tick(4);
        t_defaults();
        t_write();
        t_soft();
        t_faults();
        end_sim();
    end
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        fails++;
        end_sim();
    end
endmodule
